/* File: hdl/ics_pkg.sv */
// Constants for the I2C channel select target.
// Assumes a single 20 MHz system clock and synchronous reset.
package ics_pkg;
  localparam int          CLK_HZ       = 20000000;
  localparam int          NUM_CH       = 8;
  localparam int          ADDR_W       = 7;
  localparam logic [7:0]  SEL_RESET    = 8'h00;
  localparam logic [7:0]  SEL_FIELD    = 8'h07;
  localparam int          SEL_LSB      = 0;
  localparam int          SEL_MSB      = 2;
  localparam logic        RW_WRITE     = 1'b0;
  localparam logic        RW_READ      = 1'b1;
  localparam logic [2:0]  BIT_LAST     = 3'h7;
  localparam logic [2:0]  BIT_FIRST    = 3'h0;
  localparam int          RST_MIN_NS   = 500;
  localparam int          RST_MIN_CYC  =
    (RST_MIN_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam logic [4:0]  RST_CNT_MAX  = 5'(RST_MIN_CYC);
  localparam logic [6:0]  BASE_ADDR    = 7'h70;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WDATA, ST_WACK,
    ST_RDATA, ST_RACK
  } ics_state_t;
endpackage : ics_pkg

/* File: hdl/ics_sync.sv */
// Two-flop synchroniser for asynchronous pin inputs.
// Assumes the input is a level from outside the sys_clk domain.
`timescale 1ns/10ps
module ics_sync #(
  parameter int          W       = 1,
  parameter logic [W-1:0] INIT   = '1
) (
  input  wire logic         sys_clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_q;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      meta_q <= INIT;
      dout   <= INIT;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule : ics_sync

/* File: hdl/ics_target.sv */
// I2C target that holds bits 2:0 of the channel enable byte of a bus switch.
// Assumes scl and sda arrive as raw pins and are oversampled by sys_clk.
`timescale 1ns/10ps
module ics_target #(
  parameter int N_CH = ics_pkg::NUM_CH
) (
  input  wire logic            sys_clk,
  input  wire logic            reset,
  input  wire logic            rst_pin_n,
  input  wire logic [1:0]      addr_pins,
  input  wire logic            scl_in,
  input  wire logic            sda_in,
  output logic                 sda_out,
  output logic                 sda_oe,
  output logic [N_CH-1:0]      ch_enable
);
  logic [4:0]  sync_q;
  logic [1:0]  addr_s;
  logic        scl_s;
  logic        sda_s;
  logic        rstn_s;
  logic        scl_prev_q;
  logic        sda_prev_q;
  logic [4:0]  rst_cnt_q;
  logic        pin_rst;
  logic        clr;
  ics_pkg::ics_state_t state_q;
  logic [2:0]  bit_q;
  logic [7:0]  shift_q;
  logic [7:0]  pend_q;
  logic        pend_valid_q;
  logic [7:0]  sel_q;
  logic [6:0]  own_addr_q;
  logic        oe_q;

  // Address pins are pins too, so they get the same two flops
  ics_sync #(.W(5), .INIT(5'h1f)) u_sync (
    .sys_clk (sys_clk),
    .reset   (reset),
    .din     ({addr_pins, rst_pin_n, sda_in, scl_in}),
    .dout    (sync_q)
  );
  assign scl_s  = sync_q[0];
  assign sda_s  = sync_q[1];
  assign rstn_s = sync_q[2];
  assign addr_s = sync_q[4:3];

  wire scl_rise = scl_s & ~scl_prev_q;
  wire scl_fall = ~scl_s & scl_prev_q;
  wire start_c  = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  wire stop_c   = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
  wire [7:0] rx_byte = {shift_q[6:0], sda_s};
  wire addr_hit = rx_byte[7:1] == own_addr_q;
  wire [7:0] rd_byte = sel_q;
  wire bit_done = bit_q == ics_pkg::BIT_LAST;
  // Controller pulls SDA low in the ack slot to ask for more
  wire ack_seen = ~sda_s;
  wire is_read  = shift_q[0] == ics_pkg::RW_READ;

  assign pin_rst = rst_cnt_q == ics_pkg::RST_CNT_MAX;
  assign clr     = reset | pin_rst;

  // Edge history starts high so reset never fakes an edge
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
      own_addr_q <= ics_pkg::BASE_ADDR;
    end else begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
      own_addr_q <= {ics_pkg::BASE_ADDR[6:2], addr_s};
    end
  end

  // Counter saturates so a held pin keeps clr asserted;
  // shorter glitches never reach it
  always_ff @(posedge sys_clk) begin
    if (reset || rstn_s) begin
      rst_cnt_q <= 5'h00;
    end else if (!pin_rst) begin
      rst_cnt_q <= rst_cnt_q + 5'h01;
    end
  end

  // Channel register; only STOP or clr (reset or pin reset) may move it
  always_ff @(posedge sys_clk) begin
    if (clr) begin
      sel_q <= ics_pkg::SEL_RESET;
    end else if (stop_c && pend_valid_q) begin
      sel_q <= pend_q & ics_pkg::SEL_FIELD;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (clr)
      ch_enable <= '0;
    else
      ch_enable <= N_CH'(sel_q);
  end

  // Bus state machine; START and STOP win over any state
  always_ff @(posedge sys_clk) begin
    if (clr) begin
      state_q      <= ics_pkg::ST_IDLE;
      bit_q        <= ics_pkg::BIT_FIRST;
      shift_q      <= 8'h00;
      pend_q       <= 8'h00;
      pend_valid_q <= 1'b0;
      oe_q         <= 1'b0;
    end else if (start_c) begin
      state_q <= ics_pkg::ST_ADDR;
      bit_q   <= ics_pkg::BIT_FIRST;
      oe_q    <= 1'b0;
    end else if (stop_c) begin
      state_q      <= ics_pkg::ST_IDLE;
      pend_valid_q <= 1'b0;
      oe_q         <= 1'b0;
    end else begin
      case (state_q)
        ics_pkg::ST_IDLE: begin
          oe_q <= 1'b0;
        end
        ics_pkg::ST_ADDR, ics_pkg::ST_WDATA: begin
          if (scl_rise) begin
            shift_q <= rx_byte;
            bit_q   <= bit_q + 3'h1;
            if (bit_done) begin
              if (state_q == ics_pkg::ST_WDATA) begin
                pend_q       <= rx_byte;
                pend_valid_q <= 1'b1;
                state_q      <= ics_pkg::ST_WACK;
              end else if (addr_hit) begin
                state_q <= ics_pkg::ST_ADDR_ACK;
              end else begin
                state_q <= ics_pkg::ST_IDLE;
              end
            end
          end
          if (scl_fall && state_q == ics_pkg::ST_WDATA)
            oe_q <= 1'b0;
        end
        ics_pkg::ST_ADDR_ACK, ics_pkg::ST_WACK: begin
          // First fall opens the ack slot, second one ends it
          if (scl_fall) begin
            if (!oe_q) begin
              oe_q <= 1'b1;
            end else if (state_q == ics_pkg::ST_ADDR_ACK &&
                         is_read) begin
              state_q <= ics_pkg::ST_RDATA;
              shift_q <= rd_byte;
              bit_q   <= ics_pkg::BIT_FIRST;
              oe_q    <= ~rd_byte[7];
            end else begin
              state_q <= ics_pkg::ST_WDATA;
              bit_q   <= ics_pkg::BIT_FIRST;
              oe_q    <= 1'b0;
            end
          end
        end
        ics_pkg::ST_RDATA: begin
          // Next bit goes out just after SCL falls, well before it rises
          if (scl_fall) begin
            bit_q   <= bit_q + 3'h1;
            shift_q <= {shift_q[6:0], 1'b0};
            if (bit_done) begin
              state_q <= ics_pkg::ST_RACK;
              oe_q    <= 1'b0;
            end else begin
              oe_q    <= ~shift_q[6];
            end
          end
        end
        ics_pkg::ST_RACK: begin
          if (scl_rise) begin
            if (ack_seen) begin
              // Mark only: bit 7 must wait for SCL to fall
              bit_q <= ics_pkg::BIT_LAST;
            end else begin
              state_q <= ics_pkg::ST_IDLE;
            end
          end
          if (scl_fall && bit_done) begin
            state_q <= ics_pkg::ST_RDATA;
            shift_q <= rd_byte;
            bit_q   <= ics_pkg::BIT_FIRST;
            oe_q    <= ~rd_byte[7];
          end
        end
        default: state_q <= ics_pkg::ST_IDLE;
      endcase
    end
  end

  // Open drain: only ever pull low
  assign sda_out = 1'b0;
  assign sda_oe  = oe_q;
endmodule : ics_target

/* File: tb/ics_target_sva.sv */
// Port checker for the channel select target.
// Assumes one sys_clk domain with sync reset.
`timescale 1ns/10ps
module ics_target_sva #(parameter int N_CH = 8) (
  input wire logic sys_clk, reset, rst_pin_n, scl_in, sda_in,
  input wire logic sda_out, sda_oe,
  input wire logic [1:0] addr_pins,
  input wire logic [N_CH-1:0] ch_enable
);
  logic scl_q, sda_q;
  logic [7:0] low_q, hi_q, bit_q, stp_q;
  always_ff @(posedge sys_clk) begin
    scl_q <= scl_in;
    sda_q <= sda_in;
    low_q <= rst_pin_n ? 8'h00 : low_q + {7'h0, !low_q[7]};
    hi_q <= scl_in ? hi_q + {7'h0, !hi_q[7]} : 8'h00;
    bit_q <= (scl_in & scl_q & sda_q & !sda_in) ? 8'h00
           : bit_q + {7'h0, scl_in & !scl_q & !bit_q[7]};
    // Saturates, so an old stop never excuses a change
    stp_q <= (scl_in & scl_q & !sda_q & sda_in) ? 8'h00
           : reset ? 8'h80 : stp_q + {7'h0, !stp_q[7]};
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence s_stop; stp_q < 8'h0c; endsequence
  property p_por; disable iff (1'b0) reset |=> ch_enable == '0; endproperty
  a_por: assert property (p_por) else $error("reset clear");
  property p_top; ch_enable[N_CH-1:3] == '0; endproperty
  a_top: assert property (p_top) else $error("upper set");
  property p_defer; $changed(ch_enable) && rst_pin_n |-> s_stop; endproperty
  a_defer: assert property (p_defer) else $error("early");
  property p_pin; low_q > 8'h10 |-> ch_enable == '0 && !sda_oe; endproperty
  a_pin: assert property (p_pin) else $error("pin clear");
  property p_od; sda_out == 1'b0; endproperty
  a_od: assert property (p_od) else $error("drives high");
  property p_idle; hi_q > 8'h10 |-> !sda_oe; endproperty
  a_idle: assert property (p_idle) else $error("idle drive");
  property p_addr; bit_q < 8'h08 |-> !sda_oe; endproperty
  a_addr: assert property (p_addr) else $error("addr drive");
  property p_settle; $changed(ch_enable) |=> $stable(ch_enable)[*4];
  endproperty
  a_settle: assert property (p_settle) else $error("bounce");
endmodule : ics_target_sva
bind ics_target ics_target_sva #(.N_CH(N_CH)) u_ics_target_sva (
  .sys_clk   (sys_clk),
  .reset     (reset),
  .rst_pin_n (rst_pin_n),
  .scl_in    (scl_in),
  .sda_in    (sda_in),
  .sda_out   (sda_out),
  .sda_oe    (sda_oe),
  .addr_pins (addr_pins),
  .ch_enable (ch_enable)
);

/* File: tb/ics_ctl.sv */
// Upstream controller model on scl and sda.
// Assumes a pull-up forms the sda level.
`timescale 1ns/10ps
module ics_ctl (
  output logic scl_o,
  output logic sda_lo,
  input wire logic sda
);
  // Clock stands high between frames
  initial begin
    scl_o = 1'b1;
    sda_lo = 1'b0;
  end
  task automatic start();
    #100 sda_lo = 1'b1;
    #100 scl_o = 1'b0;
  endtask : start
  task automatic stop();
    #100 sda_lo = 1'b1;
    #100 scl_o = 1'b1;
    #100 sda_lo = 1'b0;
    #400;
  endtask : stop
  task automatic xfer(input logic [7:0] d, input logic m,
                      output logic [7:0] q, output logic a);
    for (int i = 8; i >= 0; i--) begin
      #100 sda_lo = (i > 0) ? !d[i-1] : !m;
      #100 scl_o = 1'b1;
      #100 if (i > 0) q[i-1] = sda; else a = sda;
      #100 scl_o = 1'b0;
    end
  endtask : xfer
endmodule : ics_ctl

/* File: tb/ics_target_tb.sv */
// Bench for the channel select target.
// Assumes the controller model and bound checker.
`timescale 1ns/10ps
module ics_target_tb;
  logic sys_clk = 1'b0, reset = 1'b1, rst_pin_n = 1'b1;
  logic [1:0] addr_pins = 2'h1;
  logic [7:0] ch_enable, q;
  logic sda_out, sda_oe, ack, scl_in, sda_lo;
  int fails = 0, num_checks = 0;
  // Pull-up on the shared data line
  wire sda_in = (sda_oe ? sda_out : 1'b1) & !sda_lo;
  ics_target u_ics_target (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .rst_pin_n (rst_pin_n),
    .addr_pins (addr_pins),
    .scl_in    (scl_in),
    .sda_in    (sda_in),
    .sda_out   (sda_out),
    .sda_oe    (sda_oe),
    .ch_enable (ch_enable)
  );
  ics_ctl u_ics_ctl (.scl_o(scl_in), .sda_lo(sda_lo), .sda(sda_in));
  initial forever #25 sys_clk = !sys_clk;
  task automatic chk(input string n, input logic [7:0] e, g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  task automatic tx(input logic [7:0] d, input logic m);
    u_ics_ctl.xfer(d, m, q, ack);
  endtask : tx
  task automatic rd(input int n, input logic [7:0] e);
    u_ics_ctl.start();
    tx(8'he3, 1'b1);
    chk("rack", 8'h00, {7'h0, ack});
    for (int i = 0; i < n; i++) begin
      tx(8'hff, i == n - 1);
      chk("rdat", e, q);
    end
    u_ics_ctl.stop();
  endtask : rd
  initial begin
    repeat (4) @(negedge sys_clk);
    reset = 1'b0;
    repeat (4) @(negedge sys_clk);
    chk("por", 8'h00, ch_enable);
    u_ics_ctl.start();
    tx(8'he2, 1'b1);
    chk("wack", 8'h00, {7'h0, ack});
    tx(8'h02, 1'b1);
    tx(8'hfd, 1'b1);
    chk("hold", 8'h00, ch_enable);
    u_ics_ctl.stop();
    chk("sel", 8'h05, ch_enable);
    rd(3, 8'h05);
    u_ics_ctl.start();
    tx(8'he4, 1'b1);
    chk("nack", 8'h01, {7'h0, ack});
    tx(8'h00, 1'b1);
    u_ics_ctl.stop();
    chk("keep", 8'h05, ch_enable);
    rst_pin_n = 1'b0;
    repeat (24) @(negedge sys_clk);
    rst_pin_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    chk("pin", 8'h00, ch_enable);
    rd(1, 8'h00);
    addr_pins = 2'h2;
    repeat (4) @(negedge sys_clk);
    u_ics_ctl.start();
    tx(8'he4, 1'b1);
    chk("wack2", 8'h00, {7'h0, ack});
    tx(8'h03, 1'b1);
    u_ics_ctl.stop();
    chk("sel2", 8'h03, ch_enable);
    report_and_stop();
  end
endmodule : ics_target_tb
